// *** design/esh_pkg.sv ***
// Purpose: shared constants and types of the serial host port
// Assumes: one system clock, all pin inputs asynchronous to it
// Notes:   state codes, frame lengths and pin levels live here
package esh_pkg;

  // ****************************************************************
  // pin levels
  // ****************************************************************
  localparam logic STRAP_4WIRE = 1'h0;
  localparam logic STRAP_3WIRE = 1'h1;
  localparam logic DC_DATA     = 1'h1;
  localparam logic DC_COMMAND  = 1'h0;

  // ****************************************************************
  // frame lengths in serial clock rises
  // ****************************************************************
  localparam logic [3:0] FRAME_4WIRE = 4'h8;
  localparam logic [3:0] FRAME_3WIRE = 4'h9;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int T_CYCLE_MIN_NS = 250;
  // least time, rounded up to whole system cycles
  localparam int T_CYCLE_MIN_CYC =
    (T_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // synchroniser lanes
  // ****************************************************************
  localparam int SYNC_W    = 6;
  localparam int LANE_RST  = 0;
  localparam int LANE_STRP = 1;
  localparam int LANE_CSN  = 2;
  localparam int LANE_SCLK = 3;
  localparam int LANE_TRANSFER_DATA_IN = 4;
  localparam int LANE_DC   = 5;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_CAPTURE = 2'b00,
    ST_IDLE    = 2'b01,
    ST_SHIFT   = 2'b10
  } esh_state_t;

  typedef struct packed {
    logic       is_data;
    logic [7:0] value;
  } esh_wr_t;

  localparam esh_wr_t WR_RESET = '{is_data: 1'h0, value: 8'h00};

endpackage : esh_pkg

// *** design/esh_sync.sv ***
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: each lane is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module esh_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ****************************************************************
  // two stages per lane
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      logic stage1;
      logic stage2;

      // resets to zero; callers pick lanes whose idle level allows it
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          stage1 <= 1'h0;
          stage2 <= 1'h0;
        end else begin
          stage1 <= async_in[g];
          stage2 <= stage1;
        end
      end

      // each lane owns its own bit, so every bit has one driver
      assign sync_out[g] = stage2;
    end
  endgenerate

endmodule : esh_sync

// *** design/esh_host_port.sv ***
// Purpose: write-only serial host port, 4-wire and 3-wire framing
// Assumes: serial clock far slower than clk_sys, sampled not used
// Notes:   writes leave as one-cycle strobes with a registered word
`timescale 1ns/100ps
module esh_host_port #(
  parameter int CYCLE_MIN = esh_pkg::T_CYCLE_MIN_CYC
) (
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  input  wire logic            reset_n,
  input  wire logic            interface_strap,
  input  wire logic            chip_select_n,
  input  wire logic            serial_clock,
  input  wire logic            transfer_data_in,
  input  wire logic            data_command,
  input  wire logic            wave_active,
  input  wire logic            otp_active,
  input  wire logic            temp_active,
  output esh_pkg::esh_wr_t     wr_word,
  output logic                 wr_ram_stb,
  output logic                 wr_cmd_stb,
  output logic                 framing_3wire,
  output logic                 activity_flag_n,
  output logic                 cmd_while_busy,
  output logic                 clock_too_fast,
  output logic                 transfer_data_oe
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [esh_pkg::SYNC_W-1:0] pins_raw;
  logic [esh_pkg::SYNC_W-1:0] pins_s;

  // chip select and reset are inverted so idle lanes reset to zero
  assign pins_raw[esh_pkg::LANE_RST]  = ~reset_n;
  assign pins_raw[esh_pkg::LANE_STRP] = interface_strap;
  assign pins_raw[esh_pkg::LANE_CSN]  = ~chip_select_n;
  assign pins_raw[esh_pkg::LANE_SCLK] = serial_clock;
  assign pins_raw[esh_pkg::LANE_TRANSFER_DATA_IN] = transfer_data_in;
  assign pins_raw[esh_pkg::LANE_DC]   = data_command;

  esh_sync #(
    .WIDTH (esh_pkg::SYNC_W)
  ) u_sync (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  wire pin_reset = pins_s[esh_pkg::LANE_RST];
  wire strap_s   = pins_s[esh_pkg::LANE_STRP];
  wire selected  = pins_s[esh_pkg::LANE_CSN];
  wire sclk_s    = pins_s[esh_pkg::LANE_SCLK];
  wire transfer_data_in_s    = pins_s[esh_pkg::LANE_TRANSFER_DATA_IN];
  wire dc_s      = pins_s[esh_pkg::LANE_DC];

  // ****************************************************************
  // serial clock edge detection
  // ****************************************************************
  logic sclk_d;

  // delay of the synchronised level, never of the first stage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclk_d <= 1'h0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d;

  // ****************************************************************
  // state and framing
  // ****************************************************************
  esh_pkg::esh_state_t state;
  esh_pkg::esh_state_t next_state;
  logic                mode_3wire;
  logic [3:0]          bit_cnt;
  logic [8:0]          shift;
  logic [1:0]          warm;

  // ones shifted in after release, as deep as the synchroniser
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      warm <= 2'h0;
    end else begin
      warm <= {warm[0], 1'h1};
    end
  end

  // strap lane reads zero until the synchroniser has filled
  wire sync_ready = warm[1];

  // strap read once after each reset release, then held static
  wire take_strap = (state == esh_pkg::ST_CAPTURE) & sync_ready;

  // frame length follows the captured strap level
  wire [3:0] frame_len = mode_3wire ? esh_pkg::FRAME_3WIRE
                                    : esh_pkg::FRAME_4WIRE;

  // a rise only counts while the host holds chip select low
  wire bit_take = (state == esh_pkg::ST_SHIFT) & selected
                  & sclk_rise;

  // msb arrives first, so bits enter from the bottom
  wire [8:0] next_shift = {shift[7:0], transfer_data_in_s};

  wire last_bit = bit_take & (bit_cnt == frame_len - 4'h1);

  // 4-wire marker is the pin on the eighth rise, 3-wire is bit one
  wire marker = mode_3wire ? next_shift[8]
                           : dc_s;
  // the D/C pin never reaches the marker in 3-wire framing
  wire marker_data = (marker == esh_pkg::DC_DATA);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      esh_pkg::ST_CAPTURE: begin
        if (sync_ready) begin
          next_state = esh_pkg::ST_IDLE;
        end
      end
      esh_pkg::ST_IDLE: begin
        if (selected) begin
          next_state = esh_pkg::ST_SHIFT;
        end
      end
      esh_pkg::ST_SHIFT: begin
        // deselect drops any partial byte
        if (!selected) begin
          next_state = esh_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = esh_pkg::ST_CAPTURE;
      end
    endcase
  end

  // ****************************************************************
  // state register and strap capture
  // ****************************************************************
  // pin reset behaves like a fresh start, strap taken again
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state      <= esh_pkg::ST_CAPTURE;
      mode_3wire <= esh_pkg::STRAP_4WIRE;
    end else if (pin_reset) begin
      state      <= esh_pkg::ST_CAPTURE;
    end else begin
      state      <= next_state;
      if (take_strap) begin
        mode_3wire <= strap_s;
      end
    end
  end

  // ****************************************************************
  // bit counter and shift register
  // ****************************************************************
  // counter restarts outside a selected shift so each byte is fresh
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bit_cnt <= 4'h0;
      shift   <= 9'h000;
    end else if (pin_reset || state != esh_pkg::ST_SHIFT
                 || !selected) begin
      bit_cnt <= 4'h0;
      shift   <= 9'h000;
    end else if (last_bit) begin
      bit_cnt <= 4'h0;
      shift   <= 9'h000;
    end else if (bit_take) begin
      bit_cnt <= bit_cnt + 4'h1;
      shift   <= next_shift;
    end
  end

  // ****************************************************************
  // write strobes and word
  // ****************************************************************
  logic busy_now;

  // word and strobes in the cycle after the closing rise
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_word    <= esh_pkg::WR_RESET;
      wr_ram_stb <= 1'h0;
      wr_cmd_stb <= 1'h0;
    end else begin
      wr_ram_stb <= last_bit & marker_data;
      wr_cmd_stb <= last_bit & ~marker_data;
      if (last_bit) begin
        wr_word.is_data <= marker_data;
        wr_word.value   <= next_shift[7:0];
      end
    end
  end

  // ****************************************************************
  // busy flag
  // ****************************************************************
  wire busy_src = wave_active | otp_active | temp_active;

  // low while waveform, otp or sensor work is in progress
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_now        <= 1'h0;
      activity_flag_n <= 1'h1;
    end else begin
      busy_now        <= busy_src;
      activity_flag_n <= ~busy_src;
    end
  end

  // a command landing while busy is flagged, still delivered
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmd_while_busy <= 1'h0;
    end else begin
      cmd_while_busy <= last_bit & ~marker_data & busy_now;
    end
  end

  // ****************************************************************
  // serial clock rate check
  // ****************************************************************
  localparam int GAP_W = $clog2(CYCLE_MIN + 1);
  localparam logic [GAP_W-1:0] GAP_MIN = GAP_W'(CYCLE_MIN);
  localparam logic [GAP_W-1:0] GAP_ONE = GAP_W'(1);

  logic [GAP_W-1:0] gap;
  logic             gap_armed;

  // gap reads one less than the cycles between rises, so the limit drops by one
  wire too_close = sclk_rise & gap_armed & (gap < GAP_MIN - GAP_ONE);

  // counts cycles between rises inside one selection only
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gap       <= '0;
      gap_armed <= 1'h0;
    end else if (!selected) begin
      gap       <= '0;
      gap_armed <= 1'h0;
    end else if (sclk_rise) begin
      gap       <= '0;
      gap_armed <= 1'h1;
    end else if (gap != GAP_MIN) begin
      gap       <= gap + GAP_ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clock_too_fast <= 1'h0;
    end else begin
      clock_too_fast <= too_close;
    end
  end

  // ****************************************************************
  // status outputs
  // ****************************************************************
  assign framing_3wire    = mode_3wire;
  // no read path exists, the data line stays an input
  assign transfer_data_oe = 1'h0;

endmodule : esh_host_port

// *** test/esh_host_model.sv ***
// Purpose: host side of the serial link, driving clock and data
// Assumes: link clock built from clk_sys, 160 ns period
// Notes:   clock rests low between frames, data released after
`timescale 1ns/100ps
module esh_host_model (
  input  wire logic clk_sys,
  output logic      serial_clock,
  output logic      transfer_data_in,
  output logic      data_command,
  output logic      chip_select_n
);
  // ******************
  // frame driver
  // ******************
  // idle levels: clock low, deselected
  initial begin
    serial_clock     = 1'h0;
    transfer_data_in = 1'h0;
    data_command     = 1'h0;
    chip_select_n    = 1'h1;
  end

  // n bits msb first; sel low leaves chip select high
  task automatic send(input logic [8:0] v, input int n,
                      input logic dc, input logic sel);
    chip_select_n <= ~sel;
    data_command  <= dc;
    repeat (8) @(posedge clk_sys);
    for (int i = n - 1; i >= 0; i--) begin
      transfer_data_in <= v[i];
      repeat (8) @(posedge clk_sys);
      serial_clock <= 1'h1;
      repeat (8) @(posedge clk_sys);
      serial_clock <= 1'h0;
    end
    repeat (8) @(posedge clk_sys);
    chip_select_n    <= 1'h1;
    // released line flips so a stale bit cannot pass for data
    transfer_data_in <= ~transfer_data_in;
    // deselect must stand long enough to pass the port's synchroniser
    repeat (8) @(posedge clk_sys);
  endtask : send
endmodule : esh_host_model

// *** test/esh_host_port_checker.sv ***
// Purpose: port-level properties of the serial host port
// Assumes: one clock domain, nrst async active low
// Notes:   strobes sit inside the high phase of the link clock
`timescale 1ns/100ps
module esh_host_port_checker (
  input wire logic             clk_sys,
  input wire logic             nrst,
  input wire logic             reset_n,
  input wire logic             interface_strap,
  input wire logic             chip_select_n,
  input wire logic             serial_clock,
  input wire logic             wave_active,
  input wire logic             otp_active,
  input wire logic             temp_active,
  input wire esh_pkg::esh_wr_t wr_word,
  input wire logic             wr_ram_stb,
  input wire logic             wr_cmd_stb,
  input wire logic             framing_3wire,
  input wire logic             activity_flag_n,
  input wire logic             transfer_data_oe
);
  // ******************
  // properties
  // ******************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire any_busy = wave_active | otp_active | temp_active;
  wire any_stb  = wr_ram_stb | wr_cmd_stb;

  chk_oe_quiet: assert property (transfer_data_oe == 1'h0)
    else $error("data line driven");
  chk_busy_low: assert property (any_busy |=> !activity_flag_n)
    else $error("busy flag not low");
  chk_busy_high: assert property (!any_busy |=> activity_flag_n)
    else $error("busy flag not high");
  chk_stb_single: assert property (any_stb |=> !any_stb)
    else $error("strobe longer than one cycle");
  chk_ram_flag: assert property
    (wr_ram_stb |-> wr_word.is_data)
    else $error("ram write without data flag");
  chk_cmd_flag: assert property
    (wr_cmd_stb |-> !wr_word.is_data)
    else $error("command write with data flag");
  chk_framing_match: assert property
    (any_stb |-> framing_3wire == interface_strap)
    else $error("framing differs from strap");
  chk_cs_gate: assert property (any_stb |-> !$past(chip_select_n, 2))
    else $error("write while deselected");
  chk_stb_on_rise: assert property (any_stb |-> serial_clock)
    else $error("write outside clock high phase");
  // pin reset leaves the word alone, yet it is excluded here too
  chk_word_hold: assert property (disable iff (!nrst || !reset_n)
    !any_stb |-> $stable(wr_word))
    else $error("word changed without strobe");

  cov_ram: cover property (wr_ram_stb);
  cov_cmd: cover property (wr_cmd_stb);
  cov_busy: cover property (any_busy ##1 !any_busy);
endmodule : esh_host_port_checker

bind esh_host_port esh_host_port_checker chk_u (.clk_sys, .nrst,
  .reset_n, .interface_strap, .chip_select_n, .serial_clock,
  .wave_active, .otp_active, .temp_active, .wr_word, .wr_ram_stb,
  .wr_cmd_stb, .framing_3wire, .activity_flag_n, .transfer_data_oe);

// *** test/test_esh_host_port.sv ***
// Purpose: self-checking bench of the serial host port
// Assumes: host model drives the link at 160 ns per bit
// Notes:   writes are queued by a monitor and judged per test
`timescale 1ns/100ps
module test_esh_host_port;
  logic             clk_sys = 1'h0;
  logic             nrst = 1'h0;
  logic             reset_n = 1'h1;
  logic             interface_strap = 1'h0;
  logic [2:0]       src = 3'h0;
  wire              wave_active = src[0];
  wire              otp_active = src[1];
  wire              temp_active = src[2];
  wire              serial_clock, transfer_data_in;
  wire              data_command, chip_select_n;
  esh_pkg::esh_wr_t wr_word;
  logic             wr_ram_stb, wr_cmd_stb, framing_3wire;
  logic             activity_flag_n, cmd_while_busy, transfer_data_oe;
  logic             clock_too_fast;
  int               mismatches = 0;
  int               num_checks = 0;
  int               busy_cmds = 0;
  int               fast_rises = 0;
  logic [9:0]       got_q[$];

  always #5 clk_sys = ~clk_sys;

  esh_host_port dut_u (.clk_sys, .nrst, .reset_n, .interface_strap,
    .chip_select_n, .serial_clock, .transfer_data_in, .data_command,
    .wave_active, .otp_active, .temp_active, .wr_word, .wr_ram_stb,
    .wr_cmd_stb, .framing_3wire, .activity_flag_n, .cmd_while_busy,
    .clock_too_fast, .transfer_data_oe);
  esh_host_model host_u (.clk_sys, .serial_clock, .transfer_data_in,
    .data_command, .chip_select_n);

  // ******************
  // monitor and compare
  // ******************
  // collect writes as {ram strobe, word}
  always @(posedge clk_sys)
    if (wr_ram_stb === 1'h1 || wr_cmd_stb === 1'h1)
      got_q.push_back({wr_ram_stb, wr_word});

  // count diagnostic pulses over the whole run
  always @(posedge clk_sys) begin
    if (cmd_while_busy === 1'h1)
      busy_cmds++;
    if (clock_too_fast === 1'h1)
      fast_rises++;
  end

  task automatic check(input string what, input logic [9:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // judge writes so far, then forget them
  task automatic expect_q(input string t, input int n,
                          input logic [9:0] e0, e1);
    check("write count", 10'(n), 10'(got_q.size()));
    if (n > 0 && got_q.size() > 0) check("first write", e0, got_q[0]);
    if (n > 1 && got_q.size() > 1) check("second write", e1, got_q[1]);
    got_q.delete();
    $display("test %s done", t);
  endtask : expect_q

  // strap set before release and kept static afterwards
  task automatic do_reset(input logic s);
    interface_strap <= s;
    nrst            <= 1'h0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'h1;
    repeat (4) @(posedge clk_sys);
    got_q.delete();
  endtask : do_reset

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // ******************
  // scenarios
  // ******************
  task automatic t_four;
    do_reset(esh_pkg::STRAP_4WIRE);
    host_u.send(9'h0a5, 8, esh_pkg::DC_DATA, 1'h1);
    host_u.send(9'h03c, 8, esh_pkg::DC_COMMAND, 1'h1);
    // bench link runs at 160 ns, below the 250 ns least period
    check("rate flag seen", 10'h001, {9'h000, fast_rises != 0});
    expect_q("four", 2, 10'h3a5, 10'h03c);
  endtask : t_four

  task automatic t_abort;
    host_u.send(9'h0ff, 5, esh_pkg::DC_DATA, 1'h1);
    host_u.send(9'h0c3, 8, esh_pkg::DC_COMMAND, 1'h1);
    expect_q("abort", 1, 10'h0c3, 10'h000);
  endtask : t_abort

  task automatic t_unselected;
    host_u.send(9'h0aa, 8, esh_pkg::DC_DATA, 1'h0);
    expect_q("unselected", 0, 10'h000, 10'h000);
  endtask : t_unselected

  // pin reset two bits into a byte drops it
  task automatic t_pin_reset;
    fork
      host_u.send(9'h0ff, 8, esh_pkg::DC_DATA, 1'h1);
      begin
        repeat (40) @(posedge clk_sys);
        reset_n <= 1'h0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'h1;
      end
    join
    host_u.send(9'h081, 8, esh_pkg::DC_DATA, 1'h1);
    expect_q("pin reset", 1, 10'h381, 10'h000);
  endtask : t_pin_reset

  // each busy source alone pulls the flag low
  task automatic t_busy;
    for (int i = 0; i < 3; i++) begin
      src <= 3'(1 << i);
      repeat (2) @(posedge clk_sys);
      #1 check("busy low", 10'h000, {9'h000, activity_flag_n});
      @(posedge clk_sys);
      src <= 3'h0;
      repeat (2) @(posedge clk_sys);
      #1 check("busy high", 10'h001, {9'h000, activity_flag_n});
      @(posedge clk_sys);
    end
    // data while busy is allowed, only commands would be flagged
    src <= 3'h1;
    host_u.send(9'h066, 8, esh_pkg::DC_DATA, 1'h1);
    src <= 3'h0;
    check("busy command flag", 10'h000, 10'(busy_cmds));
    expect_q("busy", 1, 10'h366, 10'h000);
  endtask : t_busy

  // first frame has the pin tied low yet carries data
  task automatic t_three;
    do_reset(esh_pkg::STRAP_3WIRE);
    check("framing", 10'h001, {9'h000, framing_3wire});
    host_u.send(9'h15a, 9, esh_pkg::DC_COMMAND, 1'h1);
    host_u.send(9'h012, 9, esh_pkg::DC_COMMAND, 1'h1);
    expect_q("three", 2, 10'h35a, 10'h012);
  endtask : t_three

  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end

  initial begin
    t_four();
    t_abort();
    t_unselected();
    t_pin_reset();
    t_busy();
    t_three();
    wrap_up();
  end
endmodule : test_esh_host_port
